// [logic/ocs_pkg.sv]
`default_nettype none
package ocs_pkg;

	// register byte addresses on the apb slave
	localparam logic [7:0] OCS_ADDR_CTRL = 8'h00;
	localparam logic [7:0] OCS_ADDR_TRIM = 8'h04;
	localparam logic [7:0] OCS_ADDR_CFG  = 8'h08;

	// control register field positions
	localparam int OCS_CTRL_SRC_LSB   = 0;
	localparam int OCS_CTRL_RANGE_LSB = 2;
	localparam int OCS_CTRL_FREQ_LSB  = 4;
	localparam int OCS_CTRL_REQ_BIT   = 6;
	localparam int OCS_CTRL_ENG_BIT   = 7;

	// configuration register field positions
	localparam int OCS_CFG_CLKOUT_BIT = 0;
	localparam int OCS_CFG_KEEP_BIT   = 1;

	// reset values
	localparam logic [1:0] OCS_SRC_RST   = 2'h0;
	localparam logic [1:0] OCS_RANGE_RST = 2'h0;
	localparam logic [1:0] OCS_FREQ_RST  = 2'h2;
	localparam logic [7:0] OCS_TRIM_RST  = 8'h00;

	// nominal internal oscillator frequencies in khz
	localparam int OCS_FREQ_LOW_KHZ  = 4000;
	localparam int OCS_FREQ_MID_KHZ  = 8000;
	localparam int OCS_FREQ_HIGH_KHZ = 12800;

	// rising edges of the new source needed before the switch
	localparam logic [1:0] OCS_EDGE_CHECK = 2'h2;

	// clock source encoding, also the index of the source synchroniser
	typedef enum logic [1:0] {
		OCS_SRC_INT  = 2'h0,
		OCS_SRC_PIN  = 2'h1,
		OCS_SRC_RC   = 2'h2,
		OCS_SRC_XTAL = 2'h3
	} ocs_src_e;

	// internal frequency select encoding
	typedef enum logic [1:0] {
		OCS_FREQ_LOW  = 2'h0,
		OCS_FREQ_MID  = 2'h1,
		OCS_FREQ_HIGH = 2'h2,
		OCS_FREQ_RSVD = 2'h3
	} ocs_freq_e;

	// clock switch sequencer
	typedef enum logic [2:0] {
		OCS_ST_INT,
		OCS_ST_CHECK,
		OCS_ST_SWITCH,
		OCS_ST_STOP_INT,
		OCS_ST_EXT,
		OCS_ST_RETURN
	} ocs_state_e;

	// two-signal view of a shared pin
	typedef struct packed {
		logic out;
		logic oe_n;
	} ocs_pin_s;

endpackage
`default_nettype wire

// [logic/ocs_osc_clock_source_switch.sv]
// Contract
// - bus_clock_x2 toggles on each bus_clock_x4 rise, half its rate.
// - bus clock is a quarter of the selected source clock.
// - internal oscillator offers 12.8, 8.0 or 4.0 MHz.
// - reset selects internal oscillator at 12.8 MHz.
// - 8-bit signed trim value; larger value means longer period.
// - factory trim is never loaded automatically; software copies it.
// - external source claims osc_in_pin; crystal also claims osc_out_pin.
// - after request, two external rising edges, then glitch-free switch.
// - engaged flag set first, internal oscillator stopped afterwards.
// - clearing select and request returns to the internal oscillator.
// - external clock mode uses osc_in_pin directly as bus_clock_x4.
// - external clock mode forces clock_out_pin_enable to zero.
// - crystal mode: osc_out_pin inverts osc_in_pin, enable ignored.
// - internal or RC mode: enable set drives bus_clock_x4 out.
// - internal mode releases osc_in_pin to the port logic.
// - no interrupt requests at all.
// - runs in wait; in stop only while osc_keep_in_stop is set.
// - source field: 00 internal, 01 pin, 10 RC, 11 crystal.
// - frequency field: 00 4.0, 01 8.0, 10 12.8, 11 reserved.
// - system_osc_enable stops oscillators unless keep-in-stop overrides.
// - request cleared by reset; engaged flag is read-only status.
//
// Our own choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module ocs_osc_clock_source_switch
	import ocs_pkg::*;
(
	// clock and reset
	input  wire logic          pclk,
	input  wire logic          presetn,
	// apb slave
	input  wire logic          psel,
	input  wire logic          penable,
	input  wire logic          pwrite,
	input  wire logic [7:0]    paddr,
	input  wire logic [31:0]   pwdata,
	output logic      [31:0]   prdata,
	output logic               pready,
	output logic               pslverr,
	// system integration unit
	input  wire logic          system_osc_enable,
	output logic               bus_clock_x4,
	output logic               bus_clock_x2,
	// oscillator sources
	input  wire logic          internal_osc_clock,
	input  wire logic          rc_osc_clock,
	input  wire logic          crystal_osc_clock,
	output logic               internal_osc_enable,
	output logic      [1:0]    internal_freq_select,
	output logic      [7:0]    osc_trim_value,
	output logic               rc_osc_enable,
	output logic               crystal_amp_enable,
	output logic      [1:0]    crystal_range_select,
	// pins
	input  wire logic          osc_in_pin,
	output logic               osc_in_pin_claim,
	output ocs_pkg::ocs_pin_s  osc_out_pin
);
	import ocs_pkg::*;

	// whole module state, registered in one process
	typedef struct packed {
		ocs_state_e fsm;
		logic [1:0] src_sel;
		logic [1:0] range;
		logic [1:0] freq;
		logic       req;
		logic       engaged;
		logic [7:0] trim;
		logic       clkout_en;
		logic       keep;
		logic [3:0] s1;
		logic [3:0] s2;
		logic [3:0] prv;
		logic [1:0] cur;
		logic [1:0] target;
		logic [1:0] edges;
		logic       x4;
		logic       x2;
		logic       int_run;
		logic       pready;
		logic       pslverr;
		logic [31:0] prdata;
		logic       int_en;
		logic       rc_en;
		logic       xtal_en;
		logic       in_claim;
		ocs_pin_s   out_pin;
	} ocs_st_s;

	ocs_st_s st;
	ocs_st_s next_st;

	// register select: 0 ctrl, 1 trim, 2 cfg, 3 unmapped
	function automatic logic [1:0] ocs_decode(input logic [7:0] a);
		logic [1:0] idx;
		idx = 2'h3;
		if (a == OCS_ADDR_CTRL) begin
			idx = 2'h0;
		end else if (a == OCS_ADDR_TRIM) begin
			idx = 2'h1;
		end else if (a == OCS_ADDR_CFG) begin
			idx = 2'h2;
		end
		return idx;
	endfunction

	logic [3:0] rise;
	logic [1:0] sel_idx;
	logic       osc_ok;

	// sequencer, register file and pin control
	always_comb begin
		next_st = st;
		rise    = st.s2 & ~st.prv;
		sel_idx = ocs_decode(paddr);
		// sources pass two flops; the third stage is only edge history
		next_st.s1  = {crystal_osc_clock, rc_osc_clock, osc_in_pin,
			internal_osc_clock};
		next_st.s2  = st.s1;
		next_st.prv = st.s2;

		// one wait state: pready rises in the second access cycle
		next_st.pready  = psel & penable & ~st.pready;
		next_st.pslverr = 1'b0;
		next_st.prdata  = 32'h0000_0000;
		if (psel && penable && !st.pready) begin
			next_st.pslverr = (sel_idx == 2'h3);
			if (sel_idx == 2'h0) begin
				next_st.prdata[OCS_CTRL_SRC_LSB +: 2]   = st.src_sel;
				next_st.prdata[OCS_CTRL_RANGE_LSB +: 2] = st.range;
				next_st.prdata[OCS_CTRL_FREQ_LSB +: 2]  = st.freq;
				next_st.prdata[OCS_CTRL_REQ_BIT]        = st.req;
				next_st.prdata[OCS_CTRL_ENG_BIT]        = st.engaged;
			end else if (sel_idx == 2'h1) begin
				next_st.prdata[7:0] = st.trim;
			end else if (sel_idx == 2'h2) begin
				next_st.prdata[OCS_CFG_CLKOUT_BIT] = st.clkout_en;
				next_st.prdata[OCS_CFG_KEEP_BIT]   = st.keep;
			end
		end

		// writes land on the edge that sees pready high
		if (psel && penable && st.pready && pwrite) begin
			if (sel_idx == 2'h0) begin
				next_st.src_sel = pwdata[OCS_CTRL_SRC_LSB +: 2];
				next_st.range   = pwdata[OCS_CTRL_RANGE_LSB +: 2];
				// frequency field, reserved code passed through
				next_st.freq    = pwdata[OCS_CTRL_FREQ_LSB +: 2];
				next_st.req     = pwdata[OCS_CTRL_REQ_BIT];
			end else if (sel_idx == 2'h1) begin
				// signed trim, only software writes it
				next_st.trim = pwdata[7:0];
			end else if (sel_idx == 2'h2) begin
				next_st.clkout_en = pwdata[OCS_CFG_CLKOUT_BIT];
				next_st.keep      = pwdata[OCS_CFG_KEEP_BIT];
			end
		end
		if (next_st.src_sel == OCS_SRC_PIN) begin
			next_st.clkout_en = 1'b0;
		end

		// switch sequencer
		case (st.fsm)
			OCS_ST_INT: begin
				next_st.edges = 2'h0;
				if (st.req && st.src_sel != OCS_SRC_INT) begin
					next_st.target = st.src_sel;
					next_st.fsm    = OCS_ST_CHECK;
				end
			end
			OCS_ST_CHECK: begin
				if (!st.req || st.src_sel != st.target) begin
					next_st.fsm = OCS_ST_INT;
				end else if (rise[st.target]) begin
					if (st.edges == OCS_EDGE_CHECK - 2'h1) begin
						next_st.fsm = OCS_ST_SWITCH;
					end else begin
						next_st.edges = st.edges + 2'h1;
					end
				end
			end
			OCS_ST_SWITCH: begin
				if (!st.req || st.src_sel != st.target) begin
					next_st.fsm = OCS_ST_INT;
				end else if (!st.x4 && !st.s2[st.target]) begin
					// both clocks low, no runt pulse
					next_st.cur     = st.target;
					next_st.engaged = 1'b1;
					next_st.fsm     = OCS_ST_STOP_INT;
				end
			end
			OCS_ST_STOP_INT: begin
				// internal oscillator stops one cycle later
				next_st.int_run = 1'b0;
				next_st.fsm     = OCS_ST_EXT;
			end
			OCS_ST_EXT: begin
				if (!st.req && st.src_sel == OCS_SRC_INT) begin
					next_st.int_run = 1'b1;
					next_st.edges   = 2'h0;
					next_st.fsm     = OCS_ST_RETURN;
				end
			end
			OCS_ST_RETURN: begin
				// wait for the restarted oscillator to show a rise
				if (st.edges == 2'h0) begin
					if (rise[OCS_SRC_INT]) begin
						next_st.edges = 2'h1;
					end
				end else if (!st.x4 && !st.s2[OCS_SRC_INT]) begin
					next_st.cur     = OCS_SRC_INT;
					// engaged drops with the switch back
					next_st.engaged = 1'b0;
					next_st.fsm     = OCS_ST_INT;
				end
			end
			default: begin
				next_st.fsm = OCS_ST_INT;
			end
		endcase

		// selected source passes straight through as x4
		next_st.x4 = st.s2[next_st.cur];
		// x2 toggles on each x4 rise
		if (next_st.x4 && !st.x4) begin
			next_st.x2 = ~st.x2;
		end

		osc_ok = system_osc_enable | st.keep;
		// internal oscillator runs at the selected frequency
		next_st.int_en  = next_st.int_run & osc_ok;
		next_st.rc_en   = (next_st.src_sel == OCS_SRC_RC) & osc_ok;
		next_st.xtal_en = (next_st.src_sel == OCS_SRC_XTAL) & osc_ok;
		// external sources claim the input pin
		next_st.in_claim = (next_st.src_sel != OCS_SRC_INT);

		// osc_out_pin: crystal amplifier, clock out or released
		if (next_st.src_sel == OCS_SRC_XTAL) begin
			next_st.out_pin.out  = ~st.s2[OCS_SRC_PIN];
			next_st.out_pin.oe_n = 1'b0;
		end else if (next_st.clkout_en &&
			next_st.src_sel != OCS_SRC_PIN) begin
			next_st.out_pin.out  = next_st.x4;
			next_st.out_pin.oe_n = 1'b0;
		end else begin
			next_st.out_pin.out  = 1'b0;
			next_st.out_pin.oe_n = 1'b1;
		end
	end

	// state register; reset values
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st           <= '0;
			st.fsm       <= OCS_ST_INT;
			st.src_sel   <= OCS_SRC_RST;
			st.range     <= OCS_RANGE_RST;
			st.freq      <= OCS_FREQ_RST;
			st.req       <= 1'b0;
			st.trim      <= OCS_TRIM_RST;
			st.cur       <= OCS_SRC_INT;
			st.int_run   <= 1'b1;
			st.int_en    <= 1'b1;
			st.out_pin   <= '{out: 1'b0, oe_n: 1'b1};
		end else begin
			st <= next_st;
		end
	end

	// outputs straight from the state register; no interrupt
	assign prdata               = st.prdata;
	assign pready               = st.pready;
	assign pslverr              = st.pslverr;
	assign bus_clock_x4         = st.x4;
	assign bus_clock_x2         = st.x2;
	assign internal_osc_enable  = st.int_en;
	assign internal_freq_select = st.freq;
	assign osc_trim_value       = st.trim;
	assign rc_osc_enable        = st.rc_en;
	assign crystal_amp_enable   = st.xtal_en;
	assign crystal_range_select = st.range;
	assign osc_in_pin_claim     = st.in_claim;
	assign osc_out_pin          = st.out_pin;

endmodule // ocs_osc_clock_source_switch
`default_nettype wire

// [testbench/ocs_source_model.sv]
`timescale 1ns/1ps
`default_nettype none
module ocs_source_model (
	// enables from the block and the bench
	input  wire logic ext_run,
	input  wire logic internal_osc_enable,
	input  wire logic rc_osc_enable,
	input  wire logic crystal_amp_enable,
	// source clocks and pin
	output logic      internal_osc_clock,
	output logic      rc_osc_clock,
	output logic      crystal_osc_clock,
	output logic      osc_in_pin
);
	// stopped sources stand still low, all slower than pclk/2
	initial begin
		{internal_osc_clock, rc_osc_clock} = 2'h0;
		{crystal_osc_clock, osc_in_pin} = 2'h0;
	end
	always #400 internal_osc_clock <= internal_osc_enable & ~internal_osc_clock;
	always #600 rc_osc_clock <= rc_osc_enable & ~rc_osc_clock;
	always #500 crystal_osc_clock <= crystal_amp_enable & ~crystal_osc_clock;
	always #700 osc_in_pin <= ext_run & ~osc_in_pin;
endmodule // ocs_source_model
`default_nettype wire

// [testbench/ocs_osc_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module ocs_osc_checker (
	// clock, reset, apb
	input wire logic           pclk,
	input wire logic           presetn,
	input wire logic           psel,
	input wire logic           penable,
	input wire logic [7:0]     paddr,
	input wire logic [31:0]    prdata,
	input wire logic           pready,
	input wire logic           pslverr,
	// clocks, controls, pins
	input wire logic           system_osc_enable,
	input wire logic           bus_clock_x4,
	input wire logic           bus_clock_x2,
	input wire logic           internal_osc_enable,
	input wire logic [1:0]     internal_freq_select,
	input wire logic [7:0]     osc_trim_value,
	input wire logic           rc_osc_enable,
	input wire logic           crystal_amp_enable,
	input wire logic           osc_in_pin_claim,
	input wire ocs_pkg::ocs_pin_s osc_out_pin
);
	import ocs_pkg::*;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// x2 moves exactly when x4 rises
	property p_half;
		$rose(bus_clock_x4) == $changed(bus_clock_x2);
	endproperty
	property p_rst;
		$rose(presetn) |-> internal_osc_enable
			&& internal_freq_select == OCS_FREQ_RST
			&& osc_trim_value == OCS_TRIM_RST;
	endproperty
	property p_claim;
		crystal_amp_enable || rc_osc_enable |-> osc_in_pin_claim;
	endproperty
	property p_xdrv;
		crystal_amp_enable |-> !osc_out_pin.oe_n;
	endproperty
	// pin mode: claim held, no local source running
	// enables lag the stop input by a cycle, so look at its past value
	property p_pinout;
		osc_in_pin_claim && $past(system_osc_enable) && !rc_osc_enable
			&& !crystal_amp_enable |-> osc_out_pin.oe_n;
	endproperty
	// clock out may lag x4 by one cycle
	property p_clkout;
		!osc_in_pin_claim && !osc_out_pin.oe_n |-> osc_out_pin.out ==
			bus_clock_x4 || osc_out_pin.out == $past(bus_clock_x4);
	endproperty
	property p_wait;
		psel && penable && !$past(penable) |-> !pready ##1 pready ##1 !pready;
	endproperty
	property p_err;
		pready && !(paddr inside {8'h00, 8'h04, 8'h08}) |->
			pslverr && prdata == 32'h0;
	endproperty
	a_half: assert property (p_half)
		else $error("x2 not half of x4");
	a_rst: assert property (p_rst)
		else $error("bad reset clock setup");
	a_claim: assert property (p_claim)
		else $error("input pin not claimed");
	a_xdrv: assert property (p_xdrv)
		else $error("amp output not driven");
	a_pinout: assert property (p_pinout)
		else $error("clock out in pin mode");
	a_clkout: assert property (p_clkout)
		else $error("clock out not x4");
	a_wait: assert property (p_wait)
		else $error("apb wait state wrong");
	a_err: assert property (p_err)
		else $error("unmapped access accepted");
	c_err: cover property (pready && pslverr);
	c_xtal: cover property ($rose(crystal_amp_enable));
	c_ext: cover property ($fell(internal_osc_enable));
	c_rc: cover property ($rose(rc_osc_enable));
endmodule // ocs_osc_checker
bind ocs_osc_clock_source_switch ocs_osc_checker i_ocs_osc_checker (
	.pclk, .presetn, .psel, .penable, .paddr, .prdata, .pready, .pslverr,
	.system_osc_enable, .bus_clock_x4, .bus_clock_x2, .internal_osc_enable,
	.internal_freq_select, .osc_trim_value, .rc_osc_enable,
	.crystal_amp_enable, .osc_in_pin_claim, .osc_out_pin
);
`default_nettype wire

// [testbench/ocs_osc_clock_source_switch_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module ocs_osc_clock_source_switch_tb_top;
	import ocs_pkg::*;
	// register write, then read-back expectation
	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wd;
		logic [31:0] exp;
	} ocs_row_s;
	ocs_row_s    rows [8] = '{'{8'h04, 32'h7f, 32'h7f}, '{8'h04, 32'h80, 32'h80},
		'{8'h08, 32'h3, 32'h3}, '{8'h00, 32'h0, 32'h0}, '{8'h00, 32'h10, 32'h10},
		'{8'h00, 32'h30, 32'h30}, '{8'h00, 32'h8c, 32'h0c}, '{8'h0c, 32'h5, 32'h0}};
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
	logic        pwrite = 1'b0, system_osc_enable = 1'b1, ext_run = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic        pready, pslverr, er, bus_clock_x4, bus_clock_x2;
	logic        internal_osc_clock, rc_osc_clock, crystal_osc_clock, osc_in_pin;
	logic        internal_osc_enable, rc_osc_enable, crystal_amp_enable;
	logic [1:0]  internal_freq_select, crystal_range_select;
	logic [7:0]  osc_trim_value;
	logic        osc_in_pin_claim;
	ocs_pin_s    osc_out_pin;
	int          n_fail = 0, checked = 0, k, n4;

	always #50 pclk = ~pclk;
	ocs_osc_clock_source_switch i_ocs_osc_clock_source_switch (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .system_osc_enable, .bus_clock_x4, .bus_clock_x2,
		.internal_osc_clock, .rc_osc_clock, .crystal_osc_clock,
		.internal_osc_enable, .internal_freq_select, .osc_trim_value,
		.rc_osc_enable, .crystal_amp_enable, .crystal_range_select,
		.osc_in_pin, .osc_in_pin_claim, .osc_out_pin);
	ocs_source_model i_ocs_source_model (
		.ext_run, .internal_osc_enable, .rc_osc_enable, .crystal_amp_enable,
		.internal_osc_clock, .rc_osc_clock, .crystal_osc_clock, .osc_in_pin);

	task automatic report_and_stop();
		if (n_fail == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one apb transfer, held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic do_reset();
		presetn <= 1'b0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
	endtask
	// poll the engaged flag, bounded
	task automatic poll(input logic want);
		k = 0;
		do begin
			apb(1'b0, 8'h00, 32'h0);
			k++;
		end while (rd[7] !== want && k < 60);
	endtask

	initial begin
		#500000;
		n_fail++;
		report_and_stop();
	end
	initial begin
		do_reset();
		for (int i = 0; i < 8; i++) begin
			apb(1'b1, rows[i].addr, rows[i].wd);
			apb(1'b0, rows[i].addr, 32'h0);
			cmp(rd, rows[i].exp);
			cmp(er, rows[i].addr == 8'h0c);
		end
		cmp(internal_freq_select, 2'h0);
		cmp(osc_trim_value, 8'h80);
		cmp(crystal_range_select, 2'h3);
		do_reset();
		apb(1'b0, 8'h00, 32'h0);
		cmp(rd, 32'h20);
		apb(1'b0, 8'h04, 32'h0);
		cmp(rd, 32'h0);
		apb(1'b1, 8'h08, 32'h3);
		repeat (3) @(posedge pclk);
		cmp(osc_out_pin.oe_n, 1'b0);
		cmp(osc_in_pin_claim, 1'b0);
		// source must be stable before the request is made
		ext_run <= 1'b1;
		repeat (60) @(posedge pclk);
		apb(1'b1, 8'h00, 32'h61);
		poll(1'b1);
		cmp(rd, 32'he1);
		cmp(internal_osc_enable, 1'b0);
		apb(1'b0, 8'h08, 32'h0);
		cmp(rd, 32'h2);
		n4 = 0;
		repeat (140) begin
			k = bus_clock_x4;
			@(posedge pclk);
			n4 += int'(bus_clock_x4 && k == 0);
		end
		cmp(n4 >= 9 && n4 <= 11, 1'b1);
		// pin clock stops, so crystal feedback sits high later on
		ext_run <= 1'b0;
		apb(1'b1, 8'h00, 32'h20);
		poll(1'b0);
		cmp(rd, 32'h20);
		cmp(internal_osc_enable, 1'b1);
		// crystal picked alone first, request left clear
		apb(1'b1, 8'h00, 32'h03);
		repeat (3) @(posedge pclk);
		cmp(crystal_amp_enable, 1'b1);
		cmp(osc_out_pin, 32'h2);
		apb(1'b1, 8'h08, 32'h0);
		system_osc_enable <= 1'b0;
		repeat (3) @(posedge pclk);
		cmp(crystal_amp_enable, 1'b0);
		apb(1'b1, 8'h08, 32'h2);
		repeat (3) @(posedge pclk);
		cmp(crystal_amp_enable, 1'b1);
		// rc source with clock out, kept alive by the keep bit
		apb(1'b1, 8'h00, 32'h02);
		apb(1'b1, 8'h08, 32'h3);
		repeat (3) @(posedge pclk);
		cmp(rc_osc_enable, 1'b1);
		cmp(crystal_amp_enable, 1'b0);
		cmp(osc_in_pin_claim, 1'b1);
		cmp(osc_out_pin.oe_n, 1'b0);
		report_and_stop();
	end
endmodule // ocs_osc_clock_source_switch_tb_top
`default_nettype wire
